// ==== include/wdu_map.svh ====
// Register map, field positions, reset values, codes and timing counts of the watchdog unit
`ifndef WDU_MAP_SVH
`define WDU_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define WDU_CTRL1_OFFSET   12'h034
`define WDU_CMD_OFFSET     12'h038
`define WDU_CFG_OFFSET     12'h03C
`define WDU_STATUS_OFFSET  12'h040

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define WDU_CTRL1_ACT_BIT  0
`define WDU_CTRL1_TSEL_LSB 1
`define WDU_CTRL1_TSEL_MSB 2
`define WDU_CTRL1_EN_BIT   3
`define WDU_CTRL1_RESET    8'h09
`define WDU_CFG_DSS_BIT    0
`define WDU_CFG_RESET      1'h0
`define WDU_CNT_MAX        2'h3

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define WDU_CODE_CLEAR     8'h4E
`define WDU_CODE_DISABLE   8'hB1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDU_DIV_W          24
`define WDU_RST_FC_PERIODS 24
`define WDU_PCLK_PER_FC    1
`define WDU_RST_CYCLES     (`WDU_RST_FC_PERIODS * `WDU_PCLK_PER_FC)

`endif

// ==== include/wdu_pkg.sv ====
// Types shared by the watchdog unit modules
package wdu_pkg;

  typedef enum logic {
    WDU_ST_DISABLED = 1'b0,
    WDU_ST_ACTIVE   = 1'b1
  } wdu_run_t;

  typedef struct packed {
    logic idle_mode;
    logic stop_mode;
  } wdu_mode_t;

  typedef struct packed {
    wdu_run_t    run;
    logic        en_bit;
    logic [1:0]  tsel;
    logic        act_sel;
    logic        dss;
    logic [1:0]  bin_cnt;
    logic        irq_pend;
    logic        irq_evt;
    logic        rst_start;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wdu_state_t;

endpackage

// ==== core/wdu_divider.sv ====
// Uncleared internal divider, stepping only while advance is high, producing the binary counter tick
`timescale 1ns/1ps
`include "wdu_map.svh"

module wdu_divider import wdu_pkg::*; #(
  parameter int DIV_W = `WDU_DIV_W
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  // Control
  input  wire logic       advance,
  input  wire logic [1:0] tsel,
  input  wire logic       dss,
  // Tick
  output logic            tick
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
  } wdu_div_state_t;

  wdu_div_state_t div_reg;
  wdu_div_state_t div_next;
  int             stage_idx;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic low_ones(input logic [DIV_W-1:0] v, input int k);
    logic r;
    r = 1'b1;
    for (int i = 0; i < DIV_W; i++) begin
      if (i <= k && !v[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Tick select: a quarter of the detection time
  // --------------------------------------------------------------------------
  always_comb begin
    stage_idx = DIV_W - 2 - 2 * int'(tsel) + int'(dss);
    tick      = advance && low_ones(div_reg.div, stage_idx);
    div_next  = div_reg;
    if (advance) begin
      div_next.div = div_reg.div + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (clk_en) begin
      div_reg <= div_next;
    end
  end

endmodule

// ==== core/wdu_rst_stretch.sv ====
// Stretches a watchdog reset start pulse to a fixed number of cycles
`timescale 1ns/1ps
`include "wdu_map.svh"

module wdu_rst_stretch import wdu_pkg::*; #(
  parameter int CYC = `WDU_RST_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // Pulse in, stretched level out
  input  wire logic start,
  output logic      rst_out
);

  localparam int CW = $clog2(CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          out;
  } wdu_stretch_t;

  wdu_stretch_t st_reg;
  wdu_stretch_t st_next;

  always_comb begin
    st_next = st_reg;
    if (start) begin
      st_next.cnt = CW'(CYC);
      st_next.out = 1'b1;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - CW'(1);
      st_next.out = (st_reg.cnt > CW'(1));
    end else begin
      st_next.out = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign rst_out = st_reg.out;

endmodule

// ==== core/wdu_watchdog.sv ====
// Watchdog timer unit top: APB registers, two-stage binary counter, overflow action
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "wdu_map.svh"

//
// Contract
// - Enable bit is 1 after reset; writing 1 to it enables the watchdog.
// - Action select resets to reset request; once written 0, writing 1 is ignored.
// - Overflow with action select 1 issues a reset request.
// - Overflow with action select 0 raises the watchdog interrupt instead.
// - Count holds in STOP and IDLE and resumes from the held value.
// - Divider feeds two-stage binary counter; clear code zeroes the binary counter and the pending interrupt, not the divider.
// - Divider is not cleared, so overflow may come at three quarters of time.
// - Timeout codes give 2^25, 2^23, 2^21, 2^19 periods; double with stage select.
// - Both control registers are write-only; reads return zero.
// - Disable code acts only when the enable bit already holds 0.
// - While disabled the binary counter stays cleared.
// - Watchdog interrupt is non-maskable.
// - A new watchdog interrupt is raised even while an earlier one is pending.
// - Watchdog reset request lasts at most 24 clock periods.
// - Disabled during interrupt service, the interrupt is not cleared until an enable bit write restarts the watchdog.

module wdu_watchdog import wdu_pkg::*; #(
  parameter int DIV_W   = `WDU_DIV_W,
  parameter int RST_CYC = `WDU_RST_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // CPU power modes
  input  wire wdu_mode_t   cpu_mode,
  // Overflow actions
  output logic             watchdog_interrupt,
  output logic             watchdog_interrupt_pulse,
  output logic             watchdog_reset_req
);

  wdu_state_t s_reg;
  wdu_state_t s_next;
  logic       hold;
  logic       tick;
  logic       acc;
  logic       wr_ctrl;
  logic       wr_cmd;
  logic       clear_hit;
  logic       disable_hit;
  logic       ovf;
  logic [7:0] code;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic mapped(input logic [11:0] a);
    return (a == `WDU_CTRL1_OFFSET) || (a == `WDU_CMD_OFFSET) ||
           (a == `WDU_CFG_OFFSET) || (a == `WDU_STATUS_OFFSET);
  endfunction

  // --------------------------------------------------------------------------
  // Divider and reset stretcher
  // --------------------------------------------------------------------------
  assign hold = cpu_mode.idle_mode || cpu_mode.stop_mode;

  wdu_divider #(
    .DIV_W   (DIV_W)
  ) u_divider (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .advance (!hold),
    .tsel    (s_reg.tsel),
    .dss     (s_reg.dss),
    .tick    (tick)
  );

  wdu_rst_stretch #(
    .CYC     (RST_CYC)
  ) u_rst_stretch (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .start   (s_reg.rst_start),
    .rst_out (watchdog_reset_req)
  );

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  always_comb begin
    acc         = psel && penable && s_reg.pready;
    wr_ctrl     = acc && pwrite && !s_reg.pslverr && (paddr == `WDU_CTRL1_OFFSET);
    wr_cmd      = acc && pwrite && !s_reg.pslverr && (paddr == `WDU_CMD_OFFSET);
    code        = pwdata[7:0];
    clear_hit   = wr_cmd && (code == `WDU_CODE_CLEAR);
    disable_hit = wr_cmd && (code == `WDU_CODE_DISABLE) && !s_reg.en_bit;
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_next           = s_reg;
    s_next.irq_evt   = 1'b0;
    s_next.rst_start = 1'b0;
    ovf              = 1'b0;

    // APB: one wait-free access phase, reads prepared in setup
    s_next.pready  = psel && !penable;
    s_next.pslverr = psel && !penable && !mapped(paddr);
    s_next.prdata  = '0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `WDU_CFG_OFFSET: begin
          s_next.prdata[`WDU_CFG_DSS_BIT] = s_reg.dss;
        end
        `WDU_STATUS_OFFSET: begin
          s_next.prdata[8:0] = {s_reg.dss, s_reg.tsel, s_reg.bin_cnt, s_reg.irq_pend,
                                s_reg.act_sel, s_reg.en_bit, s_reg.run};
        end
        default: begin
          s_next.prdata = '0;
        end
      endcase
    end

    // Counter state machine
    case (s_reg.run)
      WDU_ST_ACTIVE: begin
        if (!hold && tick) begin
          if (s_reg.bin_cnt == `WDU_CNT_MAX) begin
            ovf            = 1'b1;
            s_next.bin_cnt = 2'h0;
          end else begin
            s_next.bin_cnt = s_reg.bin_cnt + 2'h1;
          end
        end
        if (clear_hit) begin
          s_next.bin_cnt  = 2'h0;
          s_next.irq_pend = 1'b0;
        end
        if (disable_hit) begin
          s_next.run     = WDU_ST_DISABLED;
          s_next.bin_cnt = 2'h0;
        end
      end
      WDU_ST_DISABLED: begin
        s_next.bin_cnt = 2'h0;
      end
      default: begin
        s_next.run = WDU_ST_DISABLED;
      end
    endcase

    // Overflow action, set wins over clear
    if (ovf) begin
      if (s_reg.act_sel) begin
        s_next.rst_start = 1'b1;
      end else begin
        s_next.irq_evt  = 1'b1;
        s_next.irq_pend = 1'b1;
      end
    end

    // Control register one
    if (wr_ctrl) begin
      s_next.en_bit = pwdata[`WDU_CTRL1_EN_BIT];
      s_next.tsel   = pwdata[`WDU_CTRL1_TSEL_MSB:`WDU_CTRL1_TSEL_LSB];
      if (!pwdata[`WDU_CTRL1_ACT_BIT]) begin
        s_next.act_sel = 1'b0;
      end
      if (pwdata[`WDU_CTRL1_EN_BIT]) begin
        s_next.run = WDU_ST_ACTIVE;
      end
    end

    // Configuration register
    if (acc && pwrite && !s_reg.pslverr && (paddr == `WDU_CFG_OFFSET)) begin
      s_next.dss = pwdata[`WDU_CFG_DSS_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg          <= '0;
      s_reg.run      <= WDU_ST_ACTIVE;
      s_reg.en_bit   <= 1'(`WDU_CTRL1_RESET >> `WDU_CTRL1_EN_BIT);
      s_reg.act_sel  <= 1'b1;
      s_reg.dss      <= `WDU_CFG_RESET;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign prdata                   = s_reg.prdata;
  assign pready                   = s_reg.pready;
  assign pslverr                  = s_reg.pslverr;
  assign watchdog_interrupt       = s_reg.irq_pend;
  assign watchdog_interrupt_pulse = s_reg.irq_evt;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] rst_len;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_len <= 8'h00;
    end else if (clk_en) begin
      rst_len <= watchdog_reset_req ? rst_len + 8'h01 : 8'h00;
    end
  end

  a_enable_after_reset: assert property (
    $rose(presetn) |-> s_reg.en_bit && s_reg.run == WDU_ST_ACTIVE)
    else $error("watchdog not enabled after reset");

  a_enable_write: assert property (
    wr_ctrl && pwdata[`WDU_CTRL1_EN_BIT] && clk_en |=> s_reg.run == WDU_ST_ACTIVE)
    else $error("enable write did not start watchdog");

  a_action_one_shot: assert property (
    !s_reg.act_sel |=> !s_reg.act_sel)
    else $error("action select returned to reset request");

  a_reset_on_overflow: assert property (
    ovf && s_reg.act_sel && clk_en |=> s_reg.rst_start ##1 watchdog_reset_req)
    else $error("overflow did not raise reset request");

  a_irq_on_overflow: assert property (
    ovf && !s_reg.act_sel && clk_en |=> watchdog_interrupt_pulse && watchdog_interrupt
      && !s_reg.rst_start)
    else $error("overflow did not raise interrupt");

  a_irq_nested: assert property (
    ovf && !s_reg.act_sel && s_reg.irq_pend && clk_en |=> watchdog_interrupt_pulse)
    else $error("new interrupt not raised while pending");

  a_hold_in_mode: assert property (
    hold && clk_en && !clear_hit && !disable_hit |=> s_reg.bin_cnt == $past(s_reg.bin_cnt))
    else $error("counter moved in idle or stop");

  a_clear_zeroes: assert property (
    clear_hit && clk_en |=> s_reg.bin_cnt == 2'h0)
    else $error("clear code did not zero counter");

  a_disable_gated: assert property (
    wr_cmd && code == `WDU_CODE_DISABLE && s_reg.en_bit && s_reg.run == WDU_ST_ACTIVE
      && clk_en |=> s_reg.run == WDU_ST_ACTIVE)
    else $error("disable code acted with enable bit set");

  a_disabled_cleared: assert property (
    s_reg.run == WDU_ST_DISABLED |-> s_reg.bin_cnt == 2'h0 && !ovf)
    else $error("counter not cleared while disabled");

  a_reset_width: assert property (
    rst_len <= 8'(RST_CYC))
    else $error("reset request held too long");

  a_other_code: assert property (
    wr_cmd && code != `WDU_CODE_CLEAR && code != `WDU_CODE_DISABLE && !wr_ctrl && clk_en
      |=> s_reg.run == $past(s_reg.run) && s_reg.en_bit == $past(s_reg.en_bit))
    else $error("other code changed enable state");

  c_reset_overflow: cover property (ovf && s_reg.act_sel);
  c_irq_overflow:   cover property (ovf && !s_reg.act_sel);
  c_disabled:       cover property (disable_hit ##1 s_reg.run == WDU_ST_DISABLED);

endmodule

// ==== verification/wdu_cpu_model.sv ====
// CPU-side model: takes watchdog interrupts and times reset requests
`timescale 1ns/1ps

module wdu_cpu_model (
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Watchdog outputs
  input  wire logic  nmi_pulse,
  input  wire logic  rst_req,
  // Observed state
  output logic [7:0] nest,
  output logic [7:0] rst_len
);
  logic rst_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nest    <= 8'h00;
      rst_len <= 8'h00;
      rst_q   <= 1'b0;
    end else begin
      rst_q <= rst_req;
      if (nmi_pulse) begin
        nest <= nest + 8'h01;
      end
      if (rst_req && !rst_q) begin
        rst_len <= 8'h01;
      end else if (rst_req) begin
        rst_len <= rst_len + 8'h01;
      end
    end
  end
endmodule

// ==== verification/wdu_watchdog_tb.sv ====
// Self-checking testbench of the watchdog unit
`timescale 1ns/1ps
`include "wdu_map.svh"

module wdu_watchdog_tb import wdu_pkg::*; ;
  // ----------------
  // Signals
  // ----------------
  localparam int DW = 8;
  localparam int RC = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic        wi, wip, wrr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  nest, rst_len, n0;
  wdu_mode_t   cpu_mode;
  int          err_count, checked, cyc, t;

  wdu_watchdog #(.DIV_W(DW), .RST_CYC(RC)) uut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_mode(cpu_mode), .watchdog_interrupt(wi),
    .watchdog_interrupt_pulse(wip), .watchdog_reset_req(wrr));

  wdu_cpu_model cpu (.pclk(pclk), .presetn(presetn), .nmi_pulse(wip), .rst_req(wrr),
    .nest(nest), .rst_len(rst_len));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cmd(input logic [7:0] c);
    apb(1'b1, `WDU_CMD_OFFSET, {24'h000000, c});
  endtask

  task automatic ctl(input logic [7:0] c);
    apb(1'b1, `WDU_CTRL1_OFFSET, {24'h000000, c});
  endtask

  task automatic wait_ovf(input logic r, input int lo, input int hi, input string nm);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((r ? wrr : wip) !== 1'b1 && n <= hi);
    chk(nm, 32'h1, {31'h0, n >= lo && n <= hi});
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ----------------
  // Tests
  // ----------------
  task automatic t_regs();
    apb(1'b0, `WDU_STATUS_OFFSET, 32'h0);
    chk("status after reset", 32'h00000007, rd & 32'h000001FF);
    apb(1'b0, `WDU_CTRL1_OFFSET, 32'h0);
    chk("control read", 32'h0, rd);
    apb(1'b0, `WDU_CMD_OFFSET, 32'h0);
    chk("command read", 32'h0, rd);
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    chk("unmapped error", 32'h1, {31'h0, se});
    $display("registers test done");
  endtask

  task automatic t_rst();
    cmd(`WDU_CODE_CLEAR);
    ctl(8'h0D);
    cmd(`WDU_CODE_CLEAR);
    repeat (10) begin
      repeat (12) @(posedge pclk);
      cmd(`WDU_CODE_CLEAR);
    end
    chk("no reset while cleared", 32'h0, {24'h0, rst_len});
    wait_ovf(1'b1, 22, 36, "reset time");
    chk("no interrupt", 32'h0, {31'h0, wi});
    repeat (RC + 2) @(posedge pclk);
    chk("reset length", RC, {24'h0, rst_len});
    do_reset();
    $display("reset test done");
  endtask

  task automatic t_irq();
    ctl(8'h08);
    for (int ts = 0; ts < 4; ts++) begin
      for (int ds = 0; ds < 2; ds++) begin
        cmd(`WDU_CODE_CLEAR);
        ctl({4'h0, 1'b1, 2'(ts), 1'b1});
        apb(1'b1, `WDU_CFG_OFFSET, 32'(ds));
        cmd(`WDU_CODE_CLEAR);
        t = 1 << (DW + 1 - 2 * ts + ds);
        wait_ovf(1'b0, 3 * t / 4 - 2, t + 4, "interrupt time");
        chk("reset request", 32'h0, {31'h0, wrr});
      end
    end
    @(posedge pclk);
    n0 = nest;
    wait_ovf(1'b0, 0, 20, "nested interrupt");
    @(posedge pclk);
    chk("interrupt pending", 32'h1, {31'h0, wi});
    chk("nesting", {24'h0, n0 + 8'h01}, {24'h0, nest});
    $display("interrupt test done");
  endtask

  task automatic t_hold();
    for (int m = 0; m < 2; m++) begin
      cmd(`WDU_CODE_CLEAR);
      repeat (8) @(posedge pclk);
      cpu_mode <= 2'(1 << m);
      n0 = nest;
      repeat (100) @(posedge pclk);
      chk("held count", {24'h0, n0}, {24'h0, nest});
      cpu_mode <= 2'b00;
      wait_ovf(1'b0, 0, 9, "resumed count");
    end
    $display("hold test done");
  endtask

  task automatic t_off();
    cmd(`WDU_CODE_CLEAR);
    cmd(`WDU_CODE_DISABLE);
    cmd(8'h55);
    wait_ovf(1'b0, 0, 20, "disable with enable set");
    cmd(`WDU_CODE_CLEAR);
    ctl(8'h06);
    cmd(`WDU_CODE_DISABLE);
    n0 = nest;
    repeat (100) @(posedge pclk);
    apb(1'b0, `WDU_STATUS_OFFSET, 32'h0);
    chk("status while off", 32'h0, rd & 32'h00000031);
    chk("no interrupt while off", {24'h0, n0}, {24'h0, nest});
    ctl(8'h0E);
    wait_ovf(1'b0, 10, 20, "enable restart");
    ctl(8'h06);
    cmd(`WDU_CODE_DISABLE);
    cmd(`WDU_CODE_CLEAR);
    chk("pending kept", 32'h1, {31'h0, wi});
    $display("disable test done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cpu_mode = 2'b00;
    err_count = 0;
    checked = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_rst();
    t_irq();
    t_hold();
    t_off();
    wrap_up();
  end
endmodule
